// file: logic/mma_cfg.svh
`ifndef MMA_CFG_SVH
`define MMA_CFG_SVH

// Default SCL phase lengths in reference clock cycles
`define MMA_SCL_LOW_CYC   16'h0064
`define MMA_SCL_HIGH_CYC  16'h0064
`define MMA_CNT_W         16
// Bits per packet, data plus acknowledge slot
`define MMA_PKT_BITS      4'h9
`define MMA_ADDR_W        7

`endif

// file: logic/mma_pkg.sv
package mma_pkg;
    typedef enum logic [2:0] {
        MMA_IDLE,
        MMA_START,
        MMA_LOW,
        MMA_HIGH,
        MMA_STOP,
        MMA_SLAVE
    } mma_state_e;
endpackage

// file: logic/mma_sync.sv
`timescale 1ns/1ps
`include "mma_cfg.svh"

// ======================================================================
// Two-stage synchroniser for the bus lines
module mma_sync (
    input  wire logic i_ref_clk,
    input  wire logic i_rst_n,
    input  wire logic i_async,
    output logic      o_sync
);
    logic meta_ff;
    logic sync_ff;
    logic nxt_meta;
    logic nxt_sync;

    always_comb begin
        nxt_meta = i_async;
        nxt_sync = meta_ff;
    end

    // Idle bus is high, so reset to high
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_ff <= 1'b1;
            sync_ff <= 1'b1;
        end else begin
            meta_ff <= nxt_meta;
            sync_ff <= nxt_sync;
        end
    end

    assign o_sync = sync_ff;
endmodule

// file: logic/mma_arb.sv
`timescale 1ns/1ps
`include "mma_cfg.svh"

// Operation
// - Of simultaneous masters only one finishes; losers stop transmitting at once.
// - On lost arbitration switch to slave mode and check own address.
// - Contention stays invisible to slaves; bus bits remain uncorrupted.
// - Only pull SCL low or release it; wired-AND gives shortest high.
// - Combined low lasts the longest low; hold SCL low until all release.
// - Time high and low phases from the observed SCL line, not own drive.
// - Sample SDA after driving each bit; mismatch means arbitration lost.
// - Loss only when SDA released high but seen low; driving low never loses.
// - After loss leave SDA released; may clock until packet ends.
// - Arbitrate bit by bit through address and data while contenders remain.
module mma_arb
    import mma_pkg::*;
#(
    parameter logic [`MMA_CNT_W-1:0]  LOW_CYC  = `MMA_SCL_LOW_CYC,
    parameter logic [`MMA_CNT_W-1:0]  HIGH_CYC = `MMA_SCL_HIGH_CYC,
    parameter logic [`MMA_ADDR_W-1:0] OWN_ADDR = 7'h2A
) (
    input  wire logic                  i_ref_clk,
    input  wire logic                  i_arst_n,
    input  wire logic                  i_start,
    input  wire logic [7:0]            i_tx_byte,
    input  wire logic                  i_last,
    input  wire logic                  i_ack_clr,
    input  wire logic                  i_scl,
    input  wire logic                  i_sda,
    output logic                       o_scl_oe_n,
    output logic                       o_sda_oe_n,
    output logic                       o_scl_out,
    output logic                       o_sda_out,
    output logic                       o_busy,
    output logic                       o_byte_done,
    output logic                       o_arb_lost,
    output logic                       o_addr_match,
    output logic [7:0]                 o_rx_byte
);
    // ==================================================================
    // Reset release and line synchronisers
    logic rst_meta_ff;
    logic rst_ff;
    logic scl_s;
    logic sda_s;

    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rst_meta_ff <= 1'b0;
            rst_ff      <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_ff      <= rst_meta_ff;
        end
    end

    mma_sync u_scl_sync (
        .i_ref_clk (i_ref_clk),
        .i_rst_n   (rst_ff),
        .i_async   (i_scl),
        .o_sync    (scl_s)
    );

    mma_sync u_sda_sync (
        .i_ref_clk (i_ref_clk),
        .i_rst_n   (rst_ff),
        .i_async   (i_sda),
        .o_sync    (sda_s)
    );

    // ==================================================================
    // Bit engine
    mma_state_e            state_ff,   nxt_state;
    logic [`MMA_CNT_W-1:0] cnt_ff,     nxt_cnt;
    logic [3:0]            bit_ff,     nxt_bit;
    logic [7:0]            sh_ff,      nxt_sh;
    logic [7:0]            rx_ff,      nxt_rx;
    logic                  scl_dr_ff,  nxt_scl_dr;
    logic                  sda_dr_ff,  nxt_sda_dr;
    logic                  lost_ff,    nxt_lost;
    logic                  done_ff,    nxt_done;
    logic                  match_ff,   nxt_match;
    logic                  first_ff,   nxt_first;
    logic                  busy_ff,    nxt_busy;
    logic                  scl_prev_ff;
    logic                  sda_prev_ff;
    logic                  tx_bit;

    // Acknowledge slot is released so the slave can drive it
    assign tx_bit = (bit_ff == `MMA_PKT_BITS - 4'h1) ? 1'b1 : sh_ff[7];

    always_comb begin
        nxt_state  = state_ff;
        nxt_cnt    = cnt_ff;
        nxt_bit    = bit_ff;
        nxt_sh     = sh_ff;
        nxt_rx     = rx_ff;
        nxt_scl_dr = scl_dr_ff;
        nxt_sda_dr = sda_dr_ff;
        nxt_lost   = lost_ff;
        nxt_done   = 1'b0;
        nxt_match  = match_ff;
        nxt_first  = first_ff;
        // Software clear loses against a new loss in the same cycle
        if (i_ack_clr) begin
            nxt_lost = 1'b0;
        end
        case (state_ff)
            MMA_IDLE: begin
                nxt_scl_dr = 1'b1;
                nxt_sda_dr = 1'b1;
                if (i_start && scl_s && sda_s) begin
                    nxt_sda_dr = 1'b0;
                    nxt_cnt    = HIGH_CYC;
                    nxt_sh     = i_tx_byte;
                    nxt_bit    = 4'h0;
                    nxt_first  = 1'b1;
                    nxt_match  = 1'b0;
                    nxt_state  = MMA_START;
                end
            end
            MMA_START: begin
                if (cnt_ff != '0) begin
                    nxt_cnt = cnt_ff - 1'b1;
                end else begin
                    nxt_scl_dr = 1'b0;
                    nxt_cnt    = LOW_CYC;
                    nxt_state  = MMA_LOW;
                end
            end
            MMA_LOW: begin
                if (!scl_s && cnt_ff != '0) begin
                    nxt_cnt = cnt_ff - 1'b1;
                end
                if (cnt_ff == LOW_CYC - 1'b1) begin
                    nxt_sda_dr = (nxt_lost || lost_ff) ? 1'b1 : tx_bit;
                end
                if (cnt_ff == '0) begin
                    nxt_scl_dr = 1'b1;
                    if (scl_s) begin
                        nxt_cnt   = HIGH_CYC;
                        nxt_state = MMA_HIGH;
                    end
                end
            end
            MMA_HIGH: begin
                if (cnt_ff == HIGH_CYC) begin
                    // Ack slot kept out so the received byte stands after the packet
                    if (bit_ff != `MMA_PKT_BITS - 4'h1) begin
                        nxt_rx = {rx_ff[6:0], sda_s};
                    end
                    if (sda_dr_ff && !sda_s && !lost_ff && bit_ff != 4'h8) begin
                        nxt_lost = 1'b1;
                    end
                end
                // shortest high wins when another pulls low
                if (!scl_s || cnt_ff == '0) begin
                    nxt_scl_dr = 1'b0;
                    nxt_cnt    = LOW_CYC;
                    nxt_sh     = {sh_ff[6:0], 1'b0};
                    nxt_bit    = bit_ff + 4'h1;
                    nxt_state  = MMA_LOW;
                    if (bit_ff == `MMA_PKT_BITS - 4'h1) begin
                        nxt_bit   = 4'h0;
                        nxt_done  = 1'b1;
                        nxt_first = 1'b0;
                        nxt_sh    = i_tx_byte;
                        // loser stops clocking at end of packet; winner goes to stop on the last byte, else clocks on
                        if (lost_ff) begin
                            nxt_scl_dr = 1'b1;
                            nxt_sda_dr = 1'b1;
                            nxt_state  = MMA_SLAVE;
                        end else if (i_last) begin
                            // Data falls in the stop state, once the clock line is low
                            nxt_state  = MMA_STOP;
                        end
                    end else if (bit_ff == 4'h7 && first_ff && lost_ff) begin
                        // address seen, compare with own
                        // Address is the first seven bits; the eighth is direction
                        nxt_match = (rx_ff[7:1] == OWN_ADDR);
                    end
                end else begin
                    nxt_cnt = cnt_ff - 1'b1;
                end
            end
            MMA_STOP: begin
                if (!scl_dr_ff) begin
                    // low timed from line; data moves only while clock is low
                    if (!scl_s) begin
                        nxt_sda_dr = 1'b0;
                    end
                    if (cnt_ff == '0 && !sda_dr_ff) begin
                        nxt_scl_dr = 1'b1;
                        nxt_cnt    = HIGH_CYC;
                    end else if (!scl_s && cnt_ff != '0) begin
                        nxt_cnt = cnt_ff - 1'b1;
                    end
                end else if (!scl_s) begin
                    // another master still holds the clock low
                    nxt_cnt = HIGH_CYC;
                end else if (cnt_ff != '0) begin
                    nxt_cnt = cnt_ff - 1'b1;
                end else begin
                    nxt_sda_dr = 1'b1;
                    nxt_state  = MMA_IDLE;
                end
            end
            MMA_SLAVE: begin
                nxt_scl_dr = 1'b1;
                nxt_sda_dr = 1'b1;
                // Bus stop: SDA rises while SCL high
                if (scl_s && scl_prev_ff && sda_s && !sda_prev_ff) begin
                    nxt_state = MMA_IDLE;
                end
                if (i_ack_clr) begin
                    nxt_state = MMA_IDLE;
                end
            end
            default: begin
                nxt_state = MMA_IDLE;
            end
        endcase
        nxt_busy = (nxt_state != MMA_IDLE);
    end

    always_ff @(posedge i_ref_clk or negedge rst_ff) begin
        if (!rst_ff) begin
            state_ff    <= MMA_IDLE;
            cnt_ff      <= '0;
            bit_ff      <= 4'h0;
            sh_ff       <= 8'h00;
            rx_ff       <= 8'h00;
            scl_dr_ff   <= 1'b1;
            sda_dr_ff   <= 1'b1;
            lost_ff     <= 1'b0;
            done_ff     <= 1'b0;
            match_ff    <= 1'b0;
            first_ff    <= 1'b0;
            scl_prev_ff <= 1'b1;
            sda_prev_ff <= 1'b1;
            busy_ff     <= 1'b0;
        end else begin
            state_ff    <= nxt_state;
            cnt_ff      <= nxt_cnt;
            bit_ff      <= nxt_bit;
            sh_ff       <= nxt_sh;
            rx_ff       <= nxt_rx;
            scl_dr_ff   <= nxt_scl_dr;
            sda_dr_ff   <= nxt_sda_dr;
            lost_ff     <= nxt_lost;
            done_ff     <= nxt_done;
            match_ff    <= nxt_match;
            first_ff    <= nxt_first;
            scl_prev_ff <= scl_s;
            sda_prev_ff <= sda_s;
            busy_ff     <= nxt_busy;
        end
    end

    // ==================================================================
    // Outputs straight from flip-flops, except the line values tied low
    // open-drain only, never a driven high
    assign o_scl_oe_n   = scl_dr_ff;
    assign o_sda_oe_n   = sda_dr_ff;
    assign o_scl_out    = 1'b0;
    assign o_sda_out    = 1'b0;
    assign o_arb_lost   = lost_ff;
    assign o_byte_done  = done_ff;
    assign o_addr_match = match_ff;
    assign o_rx_byte    = rx_ff;
    assign o_busy       = busy_ff;
endmodule

// file: test/mma_arb_props.sv
`timescale 1ns/1ps
// ======
// Checker
module mma_arb_chk (
    input wire logic i_ref_clk,
    input wire logic i_arst_n,
    input wire logic i_ack_clr,
    input wire logic o_scl_oe_n,
    input wire logic o_sda_oe_n,
    input wire logic o_scl_out,
    input wire logic o_sda_out,
    input wire logic o_busy,
    input wire logic o_byte_done,
    input wire logic o_arb_lost,
    input wire logic o_addr_match
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_arst_n);
    property p_out0; o_scl_out == 1'b0 && o_sda_out == 1'b0; endproperty
    a_out0: assert property (p_out0) else $error("line value not low");
    property p_sticky; o_arb_lost && !i_ack_clr |=> o_arb_lost; endproperty
    a_sticky: assert property (p_sticky) else $error("lost flag dropped");
    property p_rel; o_arb_lost && $past(o_arb_lost) |-> o_sda_oe_n; endproperty
    a_rel: assert property (p_rel) else $error("loser drives data");
    property p_cause; $rose(o_arb_lost) |-> $past(o_sda_oe_n); endproperty
    a_cause: assert property (p_cause) else $error("lost while driving low");
    property p_addr; $rose(o_addr_match) |-> o_arb_lost; endproperty
    a_addr: assert property (p_addr) else $error("match without loss");
    property p_idle; !o_busy |-> o_scl_oe_n && o_sda_oe_n; endproperty
    a_idle: assert property (p_idle) else $error("idle but driving");
    property p_pulse; o_byte_done |=> !o_byte_done; endproperty
    a_pulse: assert property (p_pulse) else $error("done too long");
    property p_low; $fell(o_scl_oe_n) |=> !o_scl_oe_n [*3]; endproperty
    a_low: assert property (p_low) else $error("clock low too short");
    property p_withdraw; o_arb_lost && o_byte_done |-> o_scl_oe_n && o_sda_oe_n; endproperty
    a_withdraw: assert property (p_withdraw) else $error("loser still drives");
endmodule

bind mma_arb mma_arb_chk u_chk (
    .i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_ack_clr(i_ack_clr),
    .o_scl_oe_n(o_scl_oe_n), .o_sda_oe_n(o_sda_oe_n), .o_scl_out(o_scl_out),
    .o_sda_out(o_sda_out), .o_busy(o_busy), .o_byte_done(o_byte_done),
    .o_arb_lost(o_arb_lost), .o_addr_match(o_addr_match)
);

// file: test/mma_peer.sv
`timescale 1ns/1ps
// ======
// Second master on the shared lines
module mma_peer (
    input  wire logic       i_clk,
    input  wire logic       i_scl,
    input  wire logic       i_sda,
    input  wire logic [7:0] i_byte,
    input  wire logic [7:0] i_stretch,
    output logic            o_scl_pull,
    output logic            o_sda_pull,
    output logic            o_idle
);
    logic       act  = 1'b0;
    logic       pscl = 1'b1;
    logic       psda = 1'b1;
    logic [3:0] cnt  = 4'h0;
    logic [7:0] hold = 8'h00;
    int         tmo  = 0;
    logic       scl_q = 1'b0;
    logic       sda_q = 1'b0;
    assign o_idle     = ~act;
    assign o_scl_pull = scl_q;
    assign o_sda_pull = sda_q;
    always @(posedge i_clk) begin
        pscl <= i_scl;
        psda <= i_sda;
        tmo  <= i_scl ? tmo + 1 : 0;
        if (!act) begin
            cnt <= 4'h0;
            // Joins on a start, so both contend from bit one
            act <= psda && !i_sda && i_scl;
        end else begin
            if (pscl && !i_scl) begin
                sda_q <= (cnt < 4'h8) ? ~i_byte[4'h7 - cnt] : 1'b0;
                scl_q <= (i_stretch != 8'h00);
                hold       <= i_stretch;
                cnt        <= cnt + 4'h1;
            end else if (hold > 8'h01) begin
                hold <= hold - 8'h01;
            end else begin
                scl_q <= 1'b0;
            end
            // Long high after ack: bus handed back
            if (cnt >= 4'h9 && tmo > 30) act <= 1'b0;
        end
    end
endmodule

// file: test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    typedef struct packed {
        logic [7:0] tx;
        logic [7:0] pb;
        logic       lost;
        logic       match;
    } mma_row_s;
    mma_row_s   rows [5] = '{'{8'hA5, 8'hFF, 1'b0, 1'b0}, '{8'h54, 8'hFF, 1'b0, 1'b0},
        '{8'hFF, 8'h54, 1'b1, 1'b1}, '{8'h80, 8'h60, 1'b1, 1'b0},
        '{8'h55, 8'h54, 1'b1, 1'b1}};
    logic       i_ref_clk = 1'b0;
    logic       i_arst_n  = 1'b0;
    logic       i_start   = 1'b0;
    logic       i_last    = 1'b1;
    logic       i_ack_clr = 1'b0;
    logic [7:0] i_tx_byte = 8'h00;
    logic [7:0] pb        = 8'hFF;
    logic [7:0] stretch   = 8'h00;
    logic [7:0] bus_byte  = 8'h00;
    logic [7:0] rx;
    logic       prev_scl  = 1'b1;
    logic       scl_oe_n, sda_oe_n, busy, done, lost, match, p_scl, p_sda, p_idle, got_done;
    wire        scl_line  = scl_oe_n & ~p_scl;
    wire        sda_line  = sda_oe_n & ~p_sda;
    int         errors = 0, n_compared = 0, low_run = 0, max_low = 0, n_rise = 0;

    mma_arb #(.LOW_CYC(16'h0004), .HIGH_CYC(16'h0004)) uut (
        .i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_start(i_start),
        .i_tx_byte(i_tx_byte), .i_last(i_last), .i_ack_clr(i_ack_clr),
        .i_scl(scl_line), .i_sda(sda_line), .o_scl_oe_n(scl_oe_n), .o_sda_oe_n(sda_oe_n),
        .o_scl_out(), .o_sda_out(), .o_busy(busy), .o_byte_done(done),
        .o_arb_lost(lost), .o_addr_match(match), .o_rx_byte(rx)
    );
    mma_peer u_peer (
        .i_clk(i_ref_clk), .i_scl(scl_line), .i_sda(sda_line), .i_byte(pb),
        .i_stretch(stretch), .o_scl_pull(p_scl), .o_sda_pull(p_sda), .o_idle(p_idle)
    );

    initial begin
        forever #2.5 i_ref_clk = ~i_ref_clk;
    end
    // ======
    // Line monitor: longest clock low, first eight bits seen
    always @(posedge i_ref_clk) begin
        low_run  <= scl_line ? 0 : low_run + 1;
        max_low  <= (low_run > max_low) ? low_run : max_low;
        prev_scl <= scl_line;
        if (scl_line && !prev_scl && n_rise < 8) begin
            bus_byte <= {bus_byte[6:0], sda_line};
            n_rise   <= n_rise + 1;
        end
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string nm);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic close_out;
        if (errors == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic run_row(input mma_row_s r);
        int k;
        @(negedge i_ref_clk);
        i_tx_byte = r.tx;
        pb        = r.pb;
        i_start   = 1'b1;
        got_done  = 1'b0;
        n_rise    = 0;
        @(negedge i_ref_clk);
        i_start = 1'b0;
        for (k = 0; k < 3000; k++) begin
            @(negedge i_ref_clk);
            if (done) got_done = 1'b1;
            if (k > 20 && p_idle && (lost || !busy)) break;
        end
        if (k == 3000) errors++;
        chk({7'h0, lost}, {7'h0, r.lost}, "arb_lost");
        chk({7'h0, match}, {7'h0, r.match}, "addr_match");
        chk(bus_byte, r.lost ? r.pb : r.tx, "bus_byte");
        chk(rx, r.lost ? r.pb : r.tx, "rx_byte");
        chk({7'h0, got_done}, 8'h01, "byte_done");
        i_ack_clr = 1'b1;
        @(negedge i_ref_clk);
        i_ack_clr = 1'b0;
        repeat (2) @(negedge i_ref_clk);
        chk({6'h0, lost, busy}, 8'h00, "after_clr");
    endtask

    initial begin
        #200000;
        errors++;
        close_out();
    end
    initial begin
        repeat (16) @(negedge i_ref_clk);
        chk({4'h0, scl_oe_n, sda_oe_n, busy, lost}, 8'h0C, "reset");
        i_arst_n = 1'b1;
        repeat (4) @(negedge i_ref_clk);
        foreach (rows[i]) run_row(rows[i]);
        stretch = 8'h14;
        run_row(rows[0]);
        chk({7'h0, max_low >= 20}, 8'h01, "scl_low");
        // Reset in mid-byte: lines released at once, idle after release
        stretch   = 8'h00;
        pb        = 8'hFF;
        i_tx_byte = 8'h00;
        i_start   = 1'b1;
        @(negedge i_ref_clk);
        i_start = 1'b0;
        repeat (30) @(negedge i_ref_clk);
        i_arst_n = 1'b0;
        @(negedge i_ref_clk);
        chk({4'h0, scl_oe_n, sda_oe_n, busy, lost}, 8'h0C, "mid_reset");
        i_arst_n = 1'b1;
        repeat (4) @(negedge i_ref_clk);
        chk({4'h0, scl_oe_n, sda_oe_n, busy, lost}, 8'h0C, "after_reset");
        close_out();
    end
endmodule
